// File: pra_top.sv
// Purpose: Host random access into transmit and receive packet buffers.
// Assumes: Host strobes are synchronous to mclk and one cycle long.
// Notes: Read data appear on host_rdata two edges after the read strobe.
// Notes on behaviour
// RL1 - The pointer high register holds address bits 15 to 8.
// RL2 - The pointer low register holds address bits 7 to 0.
// RL3 - Reading the transmit port returns the transmit byte at the pointer.
// RL4 - Writing the transmit port stores the byte in the transmit buffer at the pointer.
// RL5 - Reading the receive port returns the receive byte at the pointer.
// RL6 - Writing the receive port overwrites the receive byte at the pointer.
// RL7 - The host moves one byte per data port access to the buffer it targets.
// RL8 - Random access neither disturbs nor depends on the streaming interfaces; a stream write to the host byte in the same cycle is dropped.
// RL9 - Random access and each streaming interface own separate pointers.
// RL10 - Pointer high sits at 0x08 and pointer low at 0x09.
// RL11 - The receive port sits at 0x02 and the transmit port at 0x04.
// RL12 - The host loads the pointer before any byte transfer.
// RL13 - One pointer pair addresses both buffers; the port picks the buffer.
// RL14 - All registers are reached over the 8-bit host register space.
// RL15 - The pointer keeps its value across data accesses.
`timescale 1ns/1ps
`default_nettype none
module pra_top (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic [7:0]                host_addr,
  input  wire logic                      host_wr,
  input  wire logic                      host_rd,
  input  wire logic [7:0]                host_wdata,
  output var  logic [7:0]                host_rdata,
  output var  logic                      host_rvalid,
  input  wire logic                      tx_stream_we,
  input  wire logic [pra_pkg::TX_AW-1:0] tx_stream_addr,
  input  wire logic [7:0]                tx_stream_wdata,
  output var  logic [7:0]                tx_stream_rdata,
  input  wire logic                      rx_stream_we,
  input  wire logic [pra_pkg::RX_AW-1:0] rx_stream_addr,
  input  wire logic [7:0]                rx_stream_wdata,
  output var  logic [7:0]                rx_stream_rdata
);
  logic [7:0]                ptr_hi;
  logic [7:0]                ptr_lo;
  logic [15:0]               ptr;
  logic                      hit_hi;
  logic                      hit_lo;
  logic                      hit_rx;
  logic                      hit_tx;
  logic [7:0]                tx_rd;
  logic [7:0]                rx_rd;
  logic [7:0]                tx_srd;
  logic [7:0]                rx_srd;
  pra_pkg::pra_sel_t         sel_reg;
  pra_pkg::pra_sel_t         sel_next;
  logic                      pend_reg;
  logic                      pend_next;
  logic [7:0]                ptrsnap_reg;
  logic [7:0]                ptrsnap_next;
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic                      rvalid_reg;
  logic                      rvalid_next;

  // Decode of the byte-wide host register space.
  assign hit_hi = (host_addr == pra_pkg::OFF_PTR_HI); // RL10 RL14
  assign hit_lo = (host_addr == pra_pkg::OFF_PTR_LO); // RL10
  assign hit_rx = (host_addr == pra_pkg::OFF_RX_PORT); // RL11
  assign hit_tx = (host_addr == pra_pkg::OFF_TX_PORT); // RL11

  pra_ptr_byte u_ptr_hi (
    .mclk  (mclk),
    .rst   (rst),
    .wr    (host_wr && hit_hi), // RL1 RL15
    .wdata (host_wdata),
    .q     (ptr_hi)
  );

  pra_ptr_byte u_ptr_lo (
    .mclk  (mclk),
    .rst   (rst),
    .wr    (host_wr && hit_lo), // RL2 RL15
    .wdata (host_wdata),
    .q     (ptr_lo)
  );

  // One pointer addresses both buffers; upper bits beyond each buffer wrap.
  assign ptr = {ptr_hi, ptr_lo}; // RL1 RL2 RL13

  pra_dpram #(
    .AW (pra_pkg::TX_AW)
  ) u_tx_ram (
    .mclk    (mclk),
    .a_we    (host_wr && hit_tx), // RL4 RL7
    .a_addr  (ptr[pra_pkg::TX_AW-1:0]), // RL13
    .a_wdata (host_wdata),
    .a_rdata (tx_rd), // RL3
    .b_we    (tx_stream_we), // RL8 RL9
    .b_addr  (tx_stream_addr),
    .b_wdata (tx_stream_wdata),
    .b_rdata (tx_srd)
  );

  pra_dpram #(
    .AW (pra_pkg::RX_AW)
  ) u_rx_ram (
    .mclk    (mclk),
    .a_we    (host_wr && hit_rx), // RL6 RL7
    .a_addr  (ptr[pra_pkg::RX_AW-1:0]), // RL13
    .a_wdata (host_wdata),
    .a_rdata (rx_rd), // RL5
    .b_we    (rx_stream_we), // RL8 RL9
    .b_addr  (rx_stream_addr),
    .b_wdata (rx_stream_wdata),
    .b_rdata (rx_srd)
  );

  // Read select is remembered for the cycle in which memory data are ready.
  always_comb begin
    sel_next     = pra_pkg::PRA_SEL_NONE;
    ptrsnap_next = pra_pkg::UNMAP_BYTE;
    pend_next    = host_rd;
    if (host_rd) begin
      if (hit_rx) begin
        sel_next = pra_pkg::PRA_SEL_RX;
      end else if (hit_tx) begin
        sel_next = pra_pkg::PRA_SEL_TX;
      end else if (hit_hi) begin
        sel_next     = pra_pkg::PRA_SEL_PTR;
        ptrsnap_next = ptr_hi;
      end else if (hit_lo) begin
        sel_next     = pra_pkg::PRA_SEL_PTR;
        ptrsnap_next = ptr_lo;
      end else begin
        sel_next = pra_pkg::PRA_SEL_NONE;
      end
    end
  end

  // Return path: one byte per read, unmapped addresses read as zero.
  always_comb begin
    rvalid_next = pend_reg;
    rdata_next  = rdata_reg;
    if (pend_reg) begin
      case (sel_reg)
        pra_pkg::PRA_SEL_RX:  rdata_next = rx_rd; // RL5
        pra_pkg::PRA_SEL_TX:  rdata_next = tx_rd; // RL3
        pra_pkg::PRA_SEL_PTR: rdata_next = ptrsnap_reg;
        default:              rdata_next = pra_pkg::UNMAP_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_reg     <= pra_pkg::PRA_SEL_NONE;
      pend_reg    <= 1'b0;
      ptrsnap_reg <= pra_pkg::RST_BYTE;
      rdata_reg   <= pra_pkg::RST_BYTE;
      rvalid_reg  <= 1'b0;
    end else begin
      sel_reg     <= sel_next;
      pend_reg    <= pend_next;
      ptrsnap_reg <= ptrsnap_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  assign host_rdata      = rdata_reg;
  assign host_rvalid     = rvalid_reg;
  assign tx_stream_rdata = tx_srd; // RL8
  assign rx_stream_rdata = rx_srd; // RL8
endmodule : pra_top
`default_nettype wire

// File: pra_pkg.sv
// Purpose: Shared constants for the packet RAM random access port.
// Assumes: Byte-wide host register space with an 8-bit address.
// Notes: Buffer depths are fixed at the device sizes.
package pra_pkg;
  localparam int           ADDR_W      = 8;
  localparam int           DATA_W      = 8;
  localparam int           PTR_W       = 16;
  localparam int           TX_AW       = 11;
  localparam int           RX_AW       = 12;
  localparam logic [7:0]   OFF_RX_PORT = 8'h02;
  localparam logic [7:0]   OFF_TX_PORT = 8'h04;
  localparam logic [7:0]   OFF_PTR_HI  = 8'h08;
  localparam logic [7:0]   OFF_PTR_LO  = 8'h09;
  localparam logic [7:0]   RST_BYTE    = 8'h00;
  localparam logic [7:0]   UNMAP_BYTE  = 8'h00;
  localparam int           PTR_HI_MSB  = 15;
  localparam int           PTR_HI_LSB  = 8;
  localparam int           PTR_LO_MSB  = 7;
  localparam int           PTR_LO_LSB  = 0;
  typedef enum logic [1:0] {
    PRA_SEL_NONE = 2'b00,
    PRA_SEL_RX   = 2'b01,
    PRA_SEL_TX   = 2'b10,
    PRA_SEL_PTR  = 2'b11
  } pra_sel_t;
endpackage : pra_pkg

// File: pra_dpram.sv
// Purpose: Byte memory with a host port and a streaming port.
// Assumes: Both ports on one clock; host port wins a same-address write.
// Notes: Read data come out of registers.
`timescale 1ns/1ps
`default_nettype none
module pra_dpram #(
  parameter int AW = 11
) (
  input  wire logic          mclk,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [7:0]    a_wdata,
  output var  logic [7:0]    a_rdata,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [7:0]    b_wdata,
  output var  logic [7:0]    b_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge mclk) begin
    if (b_we && !(a_we && a_addr == b_addr)) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule : pra_dpram
`default_nettype wire

// File: pra_ptr_byte.sv
// Purpose: One byte of the random access pointer.
// Assumes: Synchronous active high reset.
// Notes: Changes only on a host write or reset.
`timescale 1ns/1ps
`default_nettype none
module pra_ptr_byte (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] q
);
  logic [7:0] byte_reg;
  logic [7:0] byte_next;
  always_comb begin
    byte_next = byte_reg;
    if (wr) begin
      byte_next = wdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      byte_reg <= pra_pkg::RST_BYTE;
    end else begin
      byte_reg <= byte_next;
    end
  end
  assign q = byte_reg;
endmodule : pra_ptr_byte
`default_nettype wire

// File: pra_chk.sv
// Purpose: Checks host port timing and data.
// Assumes: Stream traffic avoids the host byte.
// Notes: Bound to pra_top.
`timescale 1ns/1ps
`default_nettype none
module pra_chk (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] host_addr,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rvalid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_w(a); host_wr && host_addr == a; endsequence
  sequence s_r(a); host_rd && host_addr == a; endsequence
  property p_lat; host_rd |-> ##2 host_rvalid; endproperty
  property p_one; host_rvalid |-> $past(host_rd, 2); endproperty
  property p_back(a); s_w(a) ##1 s_r(a) |-> ##2 host_rdata == $past(host_wdata, 3); endproperty
  property p_unm;
    host_rd && !(host_addr inside {8'h02, 8'h04, 8'h08, 8'h09}) |-> ##2 host_rdata == 8'h00;
  endproperty
  property p_hold; !host_rvalid |-> $stable(host_rdata); endproperty
  a_lat: assert property (p_lat) else $error("late answer");
  a_one: assert property (p_one) else $error("stray answer");
  a_hi: assert property (p_back(8'h08)) else $error("high byte");
  a_lo: assert property (p_back(8'h09)) else $error("low byte");
  a_tx: assert property (p_back(8'h04)) else $error("tx byte");
  a_rx: assert property (p_back(8'h02)) else $error("rx byte");
  a_unm: assert property (p_unm) else $error("unmapped");
  a_hold: assert property (p_hold) else $error("data moved");
  c_tx: cover property (s_w(8'h04) ##1 s_r(8'h04));
  c_unm: cover property (s_r(8'h03));
  c_b2b: cover property (host_rvalid ##1 host_rvalid);
endmodule : pra_chk
bind pra_top pra_chk i_chk (.mclk(mclk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
`default_nettype wire

// File: pra_host.sv
// Purpose: Host processor model.
// Assumes: One access per cycle.
// Notes: Signals change 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none
module pra_host (
  input  wire logic       mclk,
  output var  logic [7:0] host_addr,
  output var  logic       host_wr,
  output var  logic       host_rd,
  output var  logic [7:0] host_wdata
);
  initial {host_addr, host_wr, host_rd, host_wdata} = 18'h0;
  task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    #1;
    host_wr    = w;
    host_rd    = r;
    host_addr  = a;
    host_wdata = d;
    @(posedge mclk);
  endtask : op
endmodule : pra_host
`default_nettype wire

// File: packet_ram_random_access_tb.sv
// Purpose: Self-checking bench for pra_top.
// Assumes: Stream writes miss the host byte.
// Notes: Reads are queued and checked on rvalid.
`timescale 1ns/1ps
`default_nettype none
module packet_ram_random_access_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  host_addr, host_wdata, host_rdata, s_wd, tx_srd, rx_srd;
  logic        host_wr, host_rd, host_rvalid, s_we;
  logic [15:0] lfsr = 16'h7C6F;
  logic [15:0] p, d, s_addr;
  logic [7:0]  exp_q[$];
  string       nam_q[$];
  int          miscompares = 0;
  int          samples_checked = 0;
  initial forever #4 mclk = ~mclk;
  pra_host i_host (.mclk(mclk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata));
  pra_top i_dut (.mclk(mclk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .tx_stream_we(s_we),
    .tx_stream_addr(s_addr[10:0]), .tx_stream_wdata(s_wd), .tx_stream_rdata(tx_srd), .rx_stream_we(s_we),
    .rx_stream_addr(s_addr[11:0]), .rx_stream_wdata(s_wd), .rx_stream_rdata(rx_srd));
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] v);
    i_host.op(1'b1, 1'b0, a, v);
  endtask : wr
  task rd(string n, logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    nam_q.push_back(n);
    i_host.op(1'b0, 1'b1, a, ~e);
  endtask : rd
  task summarize;
    $display("checked %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(negedge mclk) if (host_rvalid === 1'b1) chk(nam_q.pop_front(), exp_q.pop_front(), host_rdata);
  initial begin
    {s_we, s_addr, s_wd} = 25'h0;
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    rd("ptr_hi_rst", 8'h08, 8'h00);
    rd("ptr_lo_rst", 8'h09, 8'h00);
    wr(8'h03, 8'h5A);
    rd("unmapped", 8'h03, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lfsr = nx(lfsr);
      p = lfsr;
      lfsr = nx(lfsr);
      d = lfsr;
      fork
        #1 {s_we, s_addr, s_wd} = {1'b1, p ^ 16'h0001, ~d[7:0]};
        i_host.op(1'b0, 1'b0, 8'h00, 8'h00);
      join
      wr(8'h08, p[15:8]);
      rd("ptr_hi", 8'h08, p[15:8]);
      wr(8'h09, p[7:0]);
      rd("ptr_lo", 8'h09, p[7:0]);
      wr(8'h04, d[15:8]);
      rd("tx_now", 8'h04, d[15:8]);
      wr(8'h02, d[7:0]);
      rd("rx_now", 8'h02, d[7:0]);
      wr(8'h03, 8'hFF);
      rd("tx_again", 8'h04, d[15:8]);
      rd("ptr_keep", 8'h08, p[15:8]);
    end
    i_host.op(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (4) @(posedge mclk);
    #1;
    chk("tx_stream", s_wd, tx_srd);
    chk("rx_stream", s_wd, rx_srd);
    chk("queue_left", 8'h00, 8'(exp_q.size()));
    $display("test random done");
    summarize();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    miscompares++;
    summarize();
  end
endmodule : packet_ram_random_access_tb
`default_nettype wire
